// ==== sms_core.sv ====
/*
  Mode decode, enable, SPI master clock, SPI slave incomplete detection and
  the I2C slave engine with its status bits. Assumes all pin inputs are
  synchronous to clk, and that the SPI shifter and select-line enable bit
  live outside and are wired in.
*/
`timescale 1ns/100ps
`include "sms_cfg.svh"

module sms_core (
  // Clock, reset, clock enable
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  // Register port
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // Configuration and neighbouring logic
  input  wire logic       configEnable,
  input  wire logic       selectLineEnable,
  input  wire logic       spiShiftBusy,
  input  wire logic       subClock,
  input  wire logic       periodCompareMatch,
  // Pins
  input  wire logic       slaveSelectLine_b,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            spiClkOut,
  // Status towards the rest of the module
  output logic            moduleActive,
  output logic            spiMasterMode,
  output logic            spiSlaveMode,
  output logic            i2cSlaveMode,
  output logic            transferDoneSet,
  output logic            serialEvent
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  sms_pkg::sms_mode_t  serialModeSelect;
  sms_pkg::sms_state_t state;
  logic [1:0] glitchFilterSelect;
  logic       serialModuleEnable;
  logic       slaveIncompleteFlag;
  logic       byteCompleteFlag;
  logic       addressHitFlag;
  logic       busBusyFlag;
  logic       transmitDirection;
  logic       ackToSend;
  logic       masterReadRequest;
  logic       addressWakeEnable;
  logic       ackReceivedFlag;
  logic [7:0] ownAddressRegister;
  logic [7:0] dataRegister;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic [5:0] divCnt;
  logic       enPrev;
  logic       selPrev;
  logic       subPrev;
  wire  [1:0] lineFilt;
  logic [1:0] linePrev;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire enEffective = serialModuleEnable & configEnable;
  wire isOff       = (serialModeSelect == sms_pkg::SMS_MODE_OFF);
  wire isI2c       = (serialModeSelect == sms_pkg::SMS_MODE_I2C);
  wire isSlave     = (serialModeSelect == sms_pkg::SMS_MODE_SLAVE);
  wire isMaster    = (serialModeSelect < sms_pkg::SMS_MODE_SLAVE);
  wire active      = enEffective & ~isOff;
  wire i2cOn       = active & isI2c;
  wire enRise      = enEffective & ~enPrev;

  wire wrMode   = regWr & (regAddr == `SMS_ADDR_MODE_CTRL);
  wire wrStatus = regWr & (regAddr == `SMS_ADDR_BUS_STATUS);
  wire wrOwn    = regWr & (regAddr == `SMS_ADDR_OWN_ADDR);
  wire wrData   = regWr & (regAddr == `SMS_ADDR_DATA);

  wire [7:0] modeView = {serialModeSelect, 1'b0, glitchFilterSelect,
                         serialModuleEnable, slaveIncompleteFlag};
  wire [7:0] statusView = {byteCompleteFlag, addressHitFlag, busBusyFlag,
                           transmitDirection, ackToSend, masterReadRequest,
                           addressWakeEnable, ackReceivedFlag};
  wire [7:0] readMux = (regAddr == `SMS_ADDR_MODE_CTRL)  ? modeView :
                       (regAddr == `SMS_ADDR_BUS_STATUS) ? statusView :
                       (regAddr == `SMS_ADDR_OWN_ADDR)   ? ownAddressRegister :
                                                           dataRegister;

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filter on SCL and SDA; SDA gets the same delay so edges keep order

  wire [2:0] filtLen = (glitchFilterSelect == 2'h0) ? `SMS_DEB_NONE :
                       (glitchFilterSelect == 2'h1) ? `SMS_DEB_SHORT :
                                                      `SMS_DEB_LONG;
  wire [1:0] lineRaw = {sdaIn, sclIn};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gFilt
      logic [2:0] stableCnt;
      logic       filtQ;
      // One process per bit owns its own flop; the vector is only a net
      assign lineFilt[gi] = filtQ;
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          stableCnt <= 3'h0;
          filtQ     <= 1'b1;
        end else if (clkEn) begin
          if (lineRaw[gi] == filtQ) begin
            stableCnt <= 3'h0;
          end else if (stableCnt + 3'h1 >= filtLen) begin
            stableCnt <= 3'h0;
            filtQ     <= lineRaw[gi];
          end else begin
            stableCnt <= stableCnt + 3'h1;
          end
        end
      end
    end
  endgenerate

  wire sclRise  = lineFilt[0] & ~linePrev[0];
  wire sclFall  = ~lineFilt[0] & linePrev[0];
  wire startCnd = lineFilt[0] & linePrev[0] & ~lineFilt[1] & linePrev[1];
  wire stopCnd  = lineFilt[0] & linePrev[0] & lineFilt[1] & ~linePrev[1];

  ////////////////////////////////////////////////////////////////////////////
  // I2C byte framing

  wire        inByte    = (state != sms_pkg::SMS_ST_IDLE);
  wire        byteDone  = sclRise & inByte & (bitCnt == 4'h7);
  wire [7:0]  shiftNext = {shiftReg[6:0], lineFilt[1]};
  wire        addrMatch = (shiftNext[7:1] == ownAddressRegister[7:1]);
  wire        ackSample = sclRise & (state == sms_pkg::SMS_ST_TX) & (bitCnt == `SMS_BIT_ACK);
  wire        ackEnd    = sclFall & inByte & (bitCnt == `SMS_BIT_END);
  wire        newByte   = ackEnd & (state != sms_pkg::SMS_ST_TX | ~ackReceivedFlag);
  wire [3:0]  fallCnt   = ackEnd ? 4'h0 : bitCnt;
  // First bit of a byte goes out at the ninth fall exactly when the next byte is TX
  wire        drvTx     = (ackEnd ? ((state == sms_pkg::SMS_ST_TX) ? ~ackReceivedFlag
                                                                   : transmitDirection)
                                  : (state == sms_pkg::SMS_ST_TX)) & (fallCnt < `SMS_BIT_ACK);
  wire        drvAck    = (bitCnt == `SMS_BIT_ACK) & ((state == sms_pkg::SMS_ST_ADDR) |
                          ((state == sms_pkg::SMS_ST_RX) & ~ackToSend));
  wire [2:0]  txIdx     = 3'h7 - fallCnt[2:0];

  sms_pkg::sms_state_t next_state;
  always_comb begin
    next_state = state;
    if (!i2cOn || stopCnd) begin
      next_state = sms_pkg::SMS_ST_IDLE;
    end else if (startCnd) begin
      next_state = sms_pkg::SMS_ST_ADDR;
    end else if (byteDone && state == sms_pkg::SMS_ST_ADDR && !addrMatch) begin
      next_state = sms_pkg::SMS_ST_IDLE;
    end else if (ackEnd) begin
      unique case (state)
        sms_pkg::SMS_ST_TX:   next_state = ackReceivedFlag ? sms_pkg::SMS_ST_IDLE
                                                           : sms_pkg::SMS_ST_TX;
        sms_pkg::SMS_ST_ADDR,
        sms_pkg::SMS_ST_RX:   next_state = transmitDirection ? sms_pkg::SMS_ST_TX
                                                             : sms_pkg::SMS_ST_RX;
        sms_pkg::SMS_ST_IDLE: next_state = sms_pkg::SMS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state    <= sms_pkg::SMS_ST_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      linePrev <= 2'h3;
    end else if (clkEn) begin
      state    <= next_state;
      linePrev <= lineFilt;
      if (startCnd || ackEnd) begin
        bitCnt <= 4'h0;
      end else if (sclRise && inByte) begin
        bitCnt   <= bitCnt + 4'h1;
        shiftReg <= shiftNext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA drive: open drain, enable high while pulling low

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sdaOut <= 1'b0;
      sdaOe  <= 1'b0;
    end else if (clkEn) begin
      sdaOut <= 1'b0;
      if (!i2cOn || stopCnd || startCnd) begin
        sdaOe <= 1'b0;
      end else if (sclFall) begin
        sdaOe <= drvTx ? ~dataRegister[txIdx] : drvAck;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C status bits; hardware events win over software writes

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      byteCompleteFlag  <= `SMS_CPL_RST;
      addressHitFlag    <= 1'b0;
      busBusyFlag       <= 1'b0;
      transmitDirection <= 1'b0;
      ackToSend         <= 1'b0;
      masterReadRequest <= 1'b0;
      addressWakeEnable <= 1'b0;
      ackReceivedFlag   <= `SMS_RXACK_RST;
    end else if (clkEn) begin
      if (wrStatus) begin
        transmitDirection <= regWrData[`SMS_DIR_BIT];
        ackToSend         <= regWrData[`SMS_TXACK_BIT];
        masterReadRequest <= regWrData[`SMS_RDREQ_BIT];
        addressWakeEnable <= regWrData[`SMS_WAKE_BIT];
      end
      if (enRise && isI2c) begin
        byteCompleteFlag  <= `SMS_CPL_RST;
        addressHitFlag    <= 1'b0;
        busBusyFlag       <= 1'b0;
        masterReadRequest <= 1'b0;
        ackReceivedFlag   <= `SMS_RXACK_RST;
      end else if (i2cOn) begin
        if (startCnd) begin
          busBusyFlag    <= 1'b1;
          addressHitFlag <= 1'b0;
        end else if (stopCnd) begin
          busBusyFlag <= 1'b0;
        end
        if (newByte) begin
          byteCompleteFlag <= 1'b0;
        end else if (byteDone) begin
          byteCompleteFlag <= 1'b1;
        end
        if (byteDone && state == sms_pkg::SMS_ST_ADDR) begin
          addressHitFlag <= addrMatch;
          if (addrMatch) begin
            masterReadRequest <= shiftNext[0];
          end
        end else if (byteDone) begin
          addressHitFlag <= 1'b0;
        end
        if (ackSample) begin
          ackReceivedFlag <= lineFilt[1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control, own address, data

  wire selRise    = slaveSelectLine_b & ~selPrev;
  wire incomplete = active & isSlave & selectLineEnable & selRise & spiShiftBusy;
  wire rxStore    = byteDone & (state == sms_pkg::SMS_ST_RX);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      serialModeSelect    <= sms_pkg::sms_mode_t'(`SMS_MODE_RST);
      glitchFilterSelect  <= `SMS_DEB_RST;
      serialModuleEnable  <= 1'b0;
      slaveIncompleteFlag <= 1'b0;
      ownAddressRegister  <= 8'h00;
      dataRegister        <= 8'h00;
      enPrev              <= 1'b0;
      selPrev             <= 1'b1;
    end else if (clkEn) begin
      enPrev  <= enEffective;
      selPrev <= slaveSelectLine_b;
      if (wrMode) begin
        serialModeSelect   <= sms_pkg::sms_mode_t'(regWrData[`SMS_MODE_MSB:`SMS_MODE_LSB]);
        glitchFilterSelect <= regWrData[`SMS_DEB_MSB:`SMS_DEB_LSB];
        serialModuleEnable <= regWrData[`SMS_EN_BIT];
      end
      if (incomplete) begin
        slaveIncompleteFlag <= 1'b1;
      end else if (wrMode) begin
        slaveIncompleteFlag <= regWrData[`SMS_INC_BIT];
      end
      if (wrOwn) begin
        ownAddressRegister <= regWrData;
      end
      if (rxStore) begin
        dataRegister <= shiftNext;
      end else if (wrData) begin
        dataRegister <= regWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI master clock; none is made in slave or I2C mode

  wire [5:0] halfDiv = (serialModeSelect == sms_pkg::SMS_MODE_MDIV4)  ? `SMS_HALF_DIV4 :
                       (serialModeSelect == sms_pkg::SMS_MODE_MDIV16) ? `SMS_HALF_DIV16 :
                                                                        `SMS_HALF_DIV64;
  wire useDiv   = (serialModeSelect < sms_pkg::SMS_MODE_MSUB);
  wire divTick  = useDiv & (divCnt >= halfDiv);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divCnt    <= 6'h00;
      spiClkOut <= 1'b0;
      subPrev   <= 1'b0;
    end else if (clkEn) begin
      subPrev <= subClock;
      if (!(active && isMaster)) begin
        divCnt    <= 6'h00;
        spiClkOut <= 1'b0;
      end else if (useDiv) begin
        divCnt <= divTick ? 6'h00 : divCnt + 6'h01;
        if (divTick) begin
          spiClkOut <= ~spiClkOut;
        end
      end else if (serialModeSelect == sms_pkg::SMS_MODE_MSUB) begin
        spiClkOut <= subPrev;
      end else if (periodCompareMatch) begin
        spiClkOut <= ~spiClkOut;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and read port

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regRdData       <= 8'h00;
      moduleActive    <= 1'b0;
      spiMasterMode   <= 1'b0;
      spiSlaveMode    <= 1'b0;
      i2cSlaveMode    <= 1'b0;
      transferDoneSet <= 1'b0;
      serialEvent     <= 1'b0;
    end else if (clkEn) begin
      regRdData       <= regRd ? readMux : 8'h00;
      moduleActive    <= active;
      spiMasterMode   <= active & isMaster;
      spiSlaveMode    <= active & isSlave;
      i2cSlaveMode    <= i2cOn;
      transferDoneSet <= incomplete;
      serialEvent     <= incomplete | (i2cOn & byteDone & (state != sms_pkg::SMS_ST_ADDR
                                                          | addrMatch));
    end
  end

endmodule : sms_core

// ==== sms_cfg.svh ====
/*
  Offsets, field positions, reset values and timing counts of the serial
  module mode and I2C slave status block. Included by the design and the bench.
*/
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH

// Register indices on the plain register port
`define SMS_ADDR_MODE_CTRL   2'h0
`define SMS_ADDR_BUS_STATUS  2'h1
`define SMS_ADDR_OWN_ADDR    2'h2
`define SMS_ADDR_DATA        2'h3

// Mode control register fields
`define SMS_MODE_MSB         7
`define SMS_MODE_LSB         5
`define SMS_DEB_MSB          3
`define SMS_DEB_LSB          2
`define SMS_EN_BIT           1
`define SMS_INC_BIT          0

// Bus status register fields
`define SMS_CPL_BIT          7
`define SMS_HIT_BIT          6
`define SMS_BUSY_BIT         5
`define SMS_DIR_BIT          4
`define SMS_TXACK_BIT        3
`define SMS_RDREQ_BIT        2
`define SMS_WAKE_BIT         1
`define SMS_RXACK_BIT        0

// Reset values
`define SMS_MODE_RST         3'h7
`define SMS_DEB_RST          2'h0
`define SMS_CPL_RST          1'h1
`define SMS_RXACK_RST        1'h1

// Glitch filter lengths in system clocks
`define SMS_DEB_NONE         3'h0
`define SMS_DEB_SHORT        3'h2
`define SMS_DEB_LONG         3'h4

// Half periods minus one, in system clocks, of the SPI master clock for the three divided rates
`define SMS_HALF_DIV4        6'h01
`define SMS_HALF_DIV16       6'h07
`define SMS_HALF_DIV64       6'h1f

// I2C bit counter values: acknowledge slot, end of acknowledge
`define SMS_BIT_ACK          4'h8
`define SMS_BIT_END          4'h9

`endif

// ==== sms_pkg.sv ====
/*
  Types of the serial module mode and I2C slave status block.
  Assumes sms_cfg.svh is on the include path.
*/
package sms_pkg;

  typedef enum logic [2:0] {
    SMS_MODE_MDIV4  = 3'b000,
    SMS_MODE_MDIV16 = 3'b001,
    SMS_MODE_MDIV64 = 3'b010,
    SMS_MODE_MSUB   = 3'b011,
    SMS_MODE_MCTM   = 3'b100,
    SMS_MODE_SLAVE  = 3'b101,
    SMS_MODE_I2C    = 3'b110,
    SMS_MODE_OFF    = 3'b111
  } sms_mode_t;

  typedef enum logic [1:0] {
    SMS_ST_IDLE = 2'b00,
    SMS_ST_ADDR = 2'b01,
    SMS_ST_RX   = 2'b10,
    SMS_ST_TX   = 2'b11
  } sms_state_t;

endpackage : sms_pkg

// ==== sms_core_chk.sv ====
/*
  Port checker of the serial module mode and I2C slave block.
  Assumes one clock domain; bound to sms_core after the module.
*/
`timescale 1ns/100ps
module sms_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Inputs
  input wire logic configEnable,
  input wire logic selectLineEnable,
  input wire logic spiShiftBusy,
  input wire logic slaveSelectLine_b,
  input wire logic sclIn,
  // Outputs
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic spiClkOut,
  input wire logic moduleActive,
  input wire logic spiMasterMode,
  input wire logic spiSlaveMode,
  input wire logic i2cSlaveMode,
  input wire logic transferDoneSet,
  input wire logic serialEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  sequence selRise;
    spiSlaveMode && selectLineEnable && spiShiftBusy && $rose(slaveSelectLine_b);
  endsequence
  sequence cfgOff;
    !configEnable ##1 !configEnable;
  endsequence
  a_mode_onehot: assert property ($onehot0({spiMasterMode, spiSlaveMode, i2cSlaveMode})
    && moduleActive == (spiMasterMode | spiSlaveMode | i2cSlaveMode))
    else $error("mode outputs disagree with active");
  a_cfg_gate: assert property (cfgOff |-> !moduleActive)
    else $error("active without configuration enable");
  a_clk_quiet: assert property (!spiMasterMode [*3] |-> !spiClkOut)
    else $error("serial clock outside master mode");
  a_sda_release: assert property (!i2cSlaveMode [*3] |-> !sdaOe)
    else $error("data line held while not in I2C mode");
  a_inc_done: assert property (selRise |-> ##[1:3] transferDoneSet)
    else $error("no transfer done after early deselect");
  a_done_event: assert property (transferDoneSet |-> serialEvent)
    else $error("incomplete without module event");
  a_done_pulse: assert property (transferDoneSet |=> !transferDoneSet)
    else $error("transfer done longer than a cycle");
  a_event_pulse: assert property (serialEvent |=> !serialEvent)
    else $error("module event longer than a cycle");
  a_ack_scl_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data line taken while clock high");
  a_ack_level: assert property (sdaOe |-> !sdaOut)
    else $error("driven data level not low");
endmodule : sms_core_chk

bind sms_core sms_core_chk chk (.clk(clk), .rst_b(rst_b), .configEnable(configEnable),
  .selectLineEnable(selectLineEnable), .spiShiftBusy(spiShiftBusy),
  .slaveSelectLine_b(slaveSelectLine_b), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .spiClkOut(spiClkOut), .moduleActive(moduleActive), .spiMasterMode(spiMasterMode),
  .spiSlaveMode(spiSlaveMode), .i2cSlaveMode(i2cSlaveMode),
  .transferDoneSet(transferDoneSet), .serialEvent(serialEvent));

// ==== sms_i2c_master.sv ====
/*
  Behavioural I2C bus master for the slave engine.
  Assumes the bench calls its tasks and feeds sdaLine to the slave.
*/
`timescale 1ns/100ps
module sms_i2c_master #(
  parameter int HALF = 12
) (
  // Clock
  input  wire logic clk,
  // Bus
  input  wire logic slaveOe,
  output logic      scl,
  output wire logic sdaLine
);
  logic sdaDrv;
  // Pull-up: the line is low while either party pulls it
  assign sdaLine = sdaDrv & ~slaveOe;
  initial begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic hp;
    repeat (HALF) @(posedge clk);
  endtask : hp
  task automatic start;
    hp();
    sdaDrv <= 1'b0;
    hp();
    scl <= 1'b0;
  endtask : start
  task automatic stop;
    hp();
    sdaDrv <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sdaDrv <= 1'b1;
    hp();
  endtask : stop
  // Data changes only mid-low so no false START or STOP is seen
  task automatic bitIo(input logic b, output logic r);
    hp();
    sdaDrv <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sdaLine;
    scl <= 1'b0;
  endtask : bitIo
  task automatic xfer(input logic [7:0] w, input logic m, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--) bitIo(w[i], r[i]);
    bitIo(m, a);
  endtask : xfer
endmodule : sms_i2c_master

// ==== tb.sv ====
/*
  Self-checking bench: register access, SPI mode checks and I2C slave
  transfers against the bus master model. Assumes sms_cfg.svh on path.
*/
`timescale 1ns/100ps
`include "sms_cfg.svh"
module tb;
  logic       clk, rst_b, clkEn, regWr, regRd, configEnable;
  logic       selectLineEnable, spiShiftBusy, subClock, periodCompareMatch;
  logic       slaveSelectLine_b, prev, a;
  logic [1:0] regAddr;
  logic [7:0] regWrData, r;
  logic [3:0] cyc = 4'h0;
  wire  [7:0] regRdData;
  wire        sdaOut, sdaOe, spiClkOut, moduleActive, spiMasterMode, spiSlaveMode;
  wire        i2cSlaveMode, transferDoneSet, serialEvent, scl, sdaLine;
  int         errCount, checksDone, doneCnt, evCnt, n, e0;
  int         rises[5] = '{64, 16, 4, 32, 8};

  sms_core DUT (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .configEnable(configEnable), .selectLineEnable(selectLineEnable),
    .spiShiftBusy(spiShiftBusy), .subClock(subClock),
    .periodCompareMatch(periodCompareMatch), .slaveSelectLine_b(slaveSelectLine_b),
    .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .spiClkOut(spiClkOut),
    .moduleActive(moduleActive), .spiMasterMode(spiMasterMode),
    .spiSlaveMode(spiSlaveMode), .i2cSlaveMode(i2cSlaveMode),
    .transferDoneSet(transferDoneSet), .serialEvent(serialEvent));
  sms_i2c_master bus (.clk(clk), .slaveOe(sdaOe), .scl(scl), .sdaLine(sdaLine));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 4'h1;
    subClock <= cyc[2];
    periodCompareMatch <= (cyc == 4'h0);
    if (transferDoneSet === 1'b1) doneCnt++;
    if (serialEvent === 1'b1) evCnt++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk);
    regAddr <= ad;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdChk(input logic [1:0] ad, input logic [7:0] m, e, input string what);
    @(posedge clk);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdData & m, e, what);
  endtask : rdChk
  task automatic selPulse;
    @(posedge clk);
    slaveSelectLine_b <= 1'b0;
    repeat (3) @(posedge clk);
    slaveSelectLine_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : selPulse
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (100000) @(posedge clk);
    errCount++;
    $display("MISMATCH at %0t: run did not finish", $time);
    conclude();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {errCount, checksDone} = '0;
    {rst_b, regWr, regRd, regAddr, regWrData} = '0;
    {selectLineEnable, spiShiftBusy, prev} = '0;
    {clkEn, configEnable, slaveSelectLine_b} = 3'h7;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdChk(`SMS_ADDR_MODE_CTRL, 8'hff, 8'he0, "mode reset");
    rdChk(`SMS_ADDR_BUS_STATUS, 8'hff, 8'h81, "status reset");
    $display("reset values done");
    // Software set of the incomplete flag, then a real early deselect
    wr(`SMS_ADDR_MODE_CTRL, 8'hb3);
    rdChk(`SMS_ADDR_MODE_CTRL, 8'hff, 8'ha3, "mode write, bit 4 reads 0");
    check({7'h0, spiSlaveMode}, 8'h01, "slave decode");
    wr(`SMS_ADDR_BUS_STATUS, 8'hff);
    rdChk(`SMS_ADDR_BUS_STATUS, 8'hff, 8'h9f, "status read-only bits");
    wr(`SMS_ADDR_MODE_CTRL, 8'hb2);
    spiShiftBusy <= 1'b1;
    selPulse();
    check(8'(doneCnt), 8'h00, "deselect ignored without select enable");
    selectLineEnable <= 1'b1;
    selPulse();
    check(8'(doneCnt), 8'h01, "one done pulse, none from software");
    rdChk(`SMS_ADDR_MODE_CTRL, 8'h01, 8'h01, "incomplete flag");
    $display("incomplete test done");
    configEnable <= 1'b0;
    wr(`SMS_ADDR_MODE_CTRL, 8'hca);
    repeat (3) @(posedge clk);
    check({7'h0, i2cSlaveMode}, 8'h00, "gated by configuration");
    configEnable <= 1'b1;
    repeat (3) @(posedge clk);
    check({7'h0, i2cSlaveMode}, 8'h01, "I2C decode");
    for (int k = 0; k < 5; k++) begin
      wr(`SMS_ADDR_MODE_CTRL, {3'(k), 5'h02});
      n = 0;
      repeat (256) begin
        @(posedge clk);
        if (spiClkOut === 1'b1 && prev === 1'b0) n++;
        prev = spiClkOut;
      end
      check({7'h0, n >= rises[k] - 1 && n <= rises[k] + 1}, 8'h01, "master clock");
      check({7'h0, spiMasterMode}, 8'h01, "master decode");
    end
    wr(`SMS_ADDR_MODE_CTRL, 8'he2);
    repeat (3) @(posedge clk);
    check({7'h0, moduleActive}, 8'h00, "mode 111 inactive");
    clkEn <= 1'b0;
    wr(`SMS_ADDR_OWN_ADDR, 8'h77);
    clkEn <= 1'b1;
    rdChk(`SMS_ADDR_OWN_ADDR, 8'hff, 8'h00, "frozen write");
    $display("mode tests done");
    // I2C: write transfer, refused byte, foreign address, read transfer
    wr(`SMS_ADDR_OWN_ADDR, 8'ha4);
    wr(`SMS_ADDR_MODE_CTRL, 8'hca);
    wr(`SMS_ADDR_BUS_STATUS, 8'h00);
    e0 = evCnt;
    bus.start();
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h20, 8'h20, "busy after start");
    bus.xfer(8'ha4, 1'b1, r, a);
    check({7'h0, a}, 8'h00, "address ack");
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h64, 8'h60, "hit, write request");
    bus.xfer(8'h3c, 1'b1, r, a);
    check({7'h0, a}, 8'h00, "data ack");
    rdChk(`SMS_ADDR_DATA, 8'hff, 8'h3c, "received byte");
    wr(`SMS_ADDR_BUS_STATUS, 8'h08);
    bus.xfer(8'hc3, 1'b1, r, a);
    check({7'h0, a}, 8'h01, "ack withheld");
    bus.stop();
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h20, 8'h00, "free after stop");
    check(8'(evCnt - e0), 8'h03, "one event per byte");
    bus.start();
    bus.xfer(8'h10, 1'b1, r, a);
    check({7'h0, a}, 8'h01, "foreign address unanswered");
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h40, 8'h00, "no hit");
    bus.stop();
    check(8'(evCnt - e0), 8'h03, "no event on mismatch");
    wr(`SMS_ADDR_DATA, 8'h5a);
    wr(`SMS_ADDR_BUS_STATUS, 8'h10);
    bus.start();
    bus.xfer(8'ha5, 1'b1, r, a);
    check({7'h0, a}, 8'h00, "read address ack");
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h64, 8'h64, "read request");
    bus.xfer(8'hff, 1'b0, r, a);
    check(r, 8'h5a, "sent byte, acked");
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h01, 8'h00, "ack received");
    bus.xfer(8'hff, 1'b1, r, a);
    check(r, 8'h5a, "sent byte, not acked");
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h01, 8'h01, "no ack received");
    bus.stop();
    wr(`SMS_ADDR_BUS_STATUS, 8'h1e);
    bus.start();
    rdChk(`SMS_ADDR_BUS_STATUS, 8'h24, 8'h24, "busy, read request set");
    wr(`SMS_ADDR_MODE_CTRL, 8'hc8);
    wr(`SMS_ADDR_MODE_CTRL, 8'hca);
    rdChk(`SMS_ADDR_BUS_STATUS, 8'hff, 8'h9b, "flags after enable rise");
    $display("I2C tests done");
    conclude();
  end
endmodule : tb
